//--- include/scb_pkg.sv
// Constants, pin groups and state layout of the serial clock/format/baud core
package scb_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] REG_CTRL1 = 3'h0;
	localparam logic [2:0] REG_CTRL2 = 3'h1;
	localparam logic [2:0] REG_BAUD = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_DATA_HI = 3'h4;
	localparam logic [2:0] REG_DATA_LO = 3'h5;
	// Field positions
	localparam int C1_MASTER = 4;
	localparam int C1_CLOCK_POLARITY = 3;
	localparam int C1_CLOCK_PHASE = 2;
	localparam int C1_SOE = 1;
	localparam int C1_LSB_FIRST_ENABLE = 0;
	localparam int C2_WLEN = 6;
	localparam int C2_FDE = 4;
	localparam int BAUD_PRE_LSB = 4;
	localparam int BAUD_RATE_LSB = 0;
	localparam int ST_RXFULL = 7;
	localparam int ST_TXEMPTY = 5;
	localparam int ST_FAULT = 4;
	// Serial clock edges in one word
	localparam logic [5:0] EDGES_8 = 6'h10;
	localparam logic [5:0] EDGES_16 = 6'h20;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_RUN = 2'b10,
		ST_TRAIL = 2'b11
	} scb_seq_t;
	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scb_bus_req_t;
	// Pin levels seen by the core
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic ss_n;
	} scb_pin_in_t;
	// Pin drives; each _oe_n is low while the core drives the pin
	typedef struct packed {
		logic sclk_o;
		logic sclk_oe_n;
		logic mosi_o;
		logic mosi_oe_n;
		logic miso_o;
		logic miso_oe_n;
		logic ss_n_o;
		logic ss_oe_n;
	} scb_pin_out_t;
	// Whole state of the core
	typedef struct packed {
		logic master_sel;
		logic clock_polarity;
		logic clock_phase;
		logic soe;
		logic lsb_first_enable;
		logic fde;
		logic wlen;
		logic [2:0] presc;
		logic [2:0] rate;
		logic rx_full;
		logic tx_empty;
		logic fault;
		logic fault_armed;
		logic [15:0] tx_buf;
		logic [7:0] tx_hi;
		logic [7:0] tx_lo;
		logic hi_pend;
		logic lo_pend;
		logic [15:0] rx_data;
		logic [15:0] hold;
		logic hold_valid;
		scb_seq_t st;
		logic [15:0] sh;
		logic smp;
		logic [5:0] edge_cnt;
		logic [10:0] div_cnt;
		logic sclk_lvl;
		logic sclk_prev;
		logic sel;
		logic [7:0] rdata;
	} scb_state_t;
	// Reset image: idle, transmit buffer empty
	localparam scb_state_t STATE_RST = '{st: ST_IDLE, tx_empty: 1'b1, default: '0};
endpackage : scb_pkg

//--- src/scb_core.sv
// Serial peripheral core: clock formats, baud divider, automatic select, mode fault
//
// Summary of operation
// - Master word length change aborts transfer, goes idle, clears status.
// - Clock polarity inverts serial clock idle level and edges.
// - Phase one: bit one starts at select fall, last ends half period after the last edge.
// - Phase one: select output falls half period before first edge.
// - Phase one: slave drives output and presents first bit on select; first edge does not shift.
// - Phase one: even edges sample, odd edges after the first shift.
// - Phase one: slave select may stay low between words.
// - Phase zero: select low from bit one until half period after last.
// - Phase zero: slave drives first bit, order by lsb first, on select.
// - Phase zero: odd edges sample, even edges shift.
// - Phase zero: slave select returns high between words.
// - Prescaler divides bus clock by one through eight.
// - Rate select divides prescaler output by two through 256.
// - Divisor is (prescale plus one) times two to (rate plus one).
// - Divider runs only while master and transferring.
// - Automatic select is low during transfers and high when idle.
// - Automatic select needs master, select output and fault detect enables.
// - Mode fault detection is off while automatic select is on.
// - Master fault: select low clears master, sets fault, releases, aborts.
// - Unselected slave floats its output, ignores the clock, never shifts.
// - After the last shift received word is stored and rx full set.
// - Eight-bit mode uses low byte only; sixteen-bit moves coherent words.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module scb_core
	import scb_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire scb_bus_req_t bus,
	output logic [7:0] rdata,
	// Serial pins
	input wire scb_pin_in_t pin_in,
	output scb_pin_out_t pin_out
);

	scb_state_t s;
	scb_state_t n;
	logic [10:0] half_m1;
	logic [5:0] last_edge;
	logic mode_fault;
	logic wlen_chg;
	logic auto_ss;
	logic edge_ev;
	logic din;
	logic done;
	logic [5:0] e_num;
	logic [15:0] fin;

	// Shift one place toward the output end, new bit in at the far end
	function automatic logic [15:0] scb_shift(input logic [15:0] v, input logic b,
		input logic lsb, input logic w16);
		logic [15:0] r;
		r = {v[14:0], b};
		if (lsb) begin
			r = {1'b0, v[15:1]};
			if (w16) begin
				r[15] = b;
			end else begin
				r[7] = b;
			end
		end
		return r;
	endfunction : scb_shift

	// Bit currently presented by the shifter
	function automatic logic scb_out_bit(input logic [15:0] v, input logic lsb,
		input logic w16);
		logic r;
		r = w16 ? v[15] : v[7];
		if (lsb) begin
			r = v[0];
		end
		return r;
	endfunction : scb_out_bit

	// Half serial period minus one: (prescale+1) * 2^rate bus cycles
	assign half_m1 = (({8'h00, s.presc} + 11'h001) << s.rate) - 11'h001;
	assign last_edge = s.wlen ? EDGES_16 : EDGES_8;
	// Fault watch is off whenever the select pin is our own output
	assign auto_ss = s.master_sel && s.soe && s.fde;
	assign mode_fault = s.master_sel && s.fde && !s.soe && !pin_in.ss_n;
	assign wlen_chg = bus.wr && (bus.addr == REG_CTRL2) && s.master_sel
		&& (bus.wdata[C2_WLEN] != s.wlen);

	// Pin drives straight from state flops; polarity is a plain inversion
	assign pin_out.sclk_o = s.sclk_lvl ^ s.clock_polarity;
	assign pin_out.sclk_oe_n = !s.master_sel;
	assign pin_out.mosi_o = scb_out_bit(s.sh, s.lsb_first_enable, s.wlen);
	assign pin_out.mosi_oe_n = !s.master_sel;
	assign pin_out.miso_o = scb_out_bit(s.sh, s.lsb_first_enable, s.wlen);
	assign pin_out.miso_oe_n = !(s.sel && !s.fault);
	assign pin_out.ss_n_o = (s.st == ST_IDLE);
	assign pin_out.ss_oe_n = !auto_ss;
	assign rdata = s.rdata;

	// Next-state logic for registers, sequencer and shifter
	always_comb begin
		n = s;
		n.rdata = 8'h00;
		edge_ev = 1'b0;
		din = 1'b0;
		done = 1'b0;
		e_num = 6'(s.edge_cnt + 6'h01);
		fin = s.sh;

		// Register writes; data only enters an empty transmit buffer
		if (bus.wr) begin
			unique case (bus.addr)
				REG_CTRL1: begin
					n.master_sel = bus.wdata[C1_MASTER];
					n.clock_polarity = bus.wdata[C1_CLOCK_POLARITY];
					n.clock_phase = bus.wdata[C1_CLOCK_PHASE];
					n.soe = bus.wdata[C1_SOE];
					n.lsb_first_enable = bus.wdata[C1_LSB_FIRST_ENABLE];
					// Status read with fault set, then this write, clears it
					if (s.fault_armed) begin
						n.fault = 1'b0;
					end
					n.fault_armed = 1'b0;
				end
				REG_CTRL2: begin
					n.fde = bus.wdata[C2_FDE];
					n.wlen = bus.wdata[C2_WLEN];
				end
				REG_BAUD: begin
					n.presc = bus.wdata[BAUD_PRE_LSB +: 3];
					n.rate = bus.wdata[BAUD_RATE_LSB +: 3];
				end
				REG_DATA_HI: begin
					if (s.wlen && s.tx_empty) begin
						if (s.lo_pend) begin
							n.tx_buf = {bus.wdata, s.tx_lo};
							n.tx_empty = 1'b0;
							n.lo_pend = 1'b0;
						end else begin
							n.tx_hi = bus.wdata;
							n.hi_pend = 1'b1;
						end
					end
				end
				REG_DATA_LO: begin
					if (s.tx_empty) begin
						if (!s.wlen) begin
							n.tx_buf = {8'h00, bus.wdata};
							n.tx_empty = 1'b0;
						end else if (s.hi_pend) begin
							n.tx_buf = {s.tx_hi, bus.wdata};
							n.tx_empty = 1'b0;
							n.hi_pend = 1'b0;
						end else begin
							n.tx_lo = bus.wdata;
							n.lo_pend = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads; a read of either data byte freezes the pair
		if (bus.rd) begin
			unique case (bus.addr)
				REG_CTRL1: begin
					n.rdata[C1_MASTER] = s.master_sel;
					n.rdata[C1_CLOCK_POLARITY] = s.clock_polarity;
					n.rdata[C1_CLOCK_PHASE] = s.clock_phase;
					n.rdata[C1_SOE] = s.soe;
					n.rdata[C1_LSB_FIRST_ENABLE] = s.lsb_first_enable;
				end
				REG_CTRL2: begin
					n.rdata[C2_FDE] = s.fde;
					n.rdata[C2_WLEN] = s.wlen;
				end
				REG_BAUD: begin
					n.rdata[BAUD_PRE_LSB +: 3] = s.presc;
					n.rdata[BAUD_RATE_LSB +: 3] = s.rate;
				end
				REG_STATUS: begin
					n.rdata[ST_RXFULL] = s.rx_full;
					n.rdata[ST_TXEMPTY] = s.tx_empty;
					n.rdata[ST_FAULT] = s.fault;
					if (s.fault) begin
						n.fault_armed = 1'b1;
					end
				end
				REG_DATA_HI: begin
					if (s.wlen) begin
						n.rdata = s.hold_valid ? s.hold[15:8] : s.rx_data[15:8];
						n.hold = s.rx_data;
						n.hold_valid = !s.hold_valid;
						if (s.hold_valid) begin
							n.hold = s.hold;
						end
					end
				end
				REG_DATA_LO: begin
					n.rdata = s.rx_data[7:0];
					n.rx_full = 1'b0;
					if (s.wlen) begin
						n.rdata = s.hold_valid ? s.hold[7:0] : s.rx_data[7:0];
						n.hold = s.hold_valid ? s.hold : s.rx_data;
						n.hold_valid = !s.hold_valid;
					end
				end
				default: begin
				end
			endcase
		end

		// Edge source: own divider as master, sampled pin as selected slave
		n.sclk_prev = pin_in.sclk;
		n.sel = !s.master_sel && !pin_in.ss_n;
		if (s.master_sel) begin
			// The lead half period ends on the first clock edge itself
			edge_ev = (s.st == ST_LEAD || s.st == ST_RUN) && (s.div_cnt == 11'h000);
			din = pin_in.miso;
		end else begin
			edge_ev = s.sel && n.sel && (pin_in.sclk != s.sclk_prev);
			din = pin_in.mosi;
		end

		// Sample and shift on alternate edges; the phase picks which
		if (edge_ev) begin
			n.edge_cnt = e_num;
			if (!s.clock_phase) begin
				if (e_num[0]) begin
					n.smp = din;
				end else begin
					n.sh = scb_shift(s.sh, s.smp, s.lsb_first_enable, s.wlen);
				end
			end else begin
				if (!e_num[0]) begin
					n.smp = din;
				end else if (e_num != 6'h01) begin
					n.sh = scb_shift(s.sh, s.smp, s.lsb_first_enable, s.wlen);
				end
			end
			// Last edge: phase one folds its final shift in here
			if (e_num == last_edge) begin
				done = 1'b1;
				fin = scb_shift(s.sh, s.clock_phase ? din : s.smp, s.lsb_first_enable, s.wlen);
				// Master phase one holds the last bit (eight or sixteen) through the trailing half period;
				// shifting on this sampling edge would race the far side's sample
				n.sh = (s.master_sel && s.clock_phase) ? s.sh : fin;
				n.rx_data = s.wlen ? fin : {8'h00, fin[7:0]};
				n.rx_full = 1'b1;
			end
		end

		// Master sequencer; the divider only counts outside idle
		if (s.master_sel) begin
			unique case (s.st)
				ST_IDLE: begin
					n.div_cnt = 11'h000;
					n.sclk_lvl = 1'b0;
					if (!s.tx_empty) begin
						n.sh = s.tx_buf;
						n.tx_empty = 1'b1;
						n.edge_cnt = 6'h00;
						n.div_cnt = half_m1;
						n.st = ST_LEAD;
					end
				end
				ST_LEAD: begin
					n.div_cnt = 11'(s.div_cnt - 11'h001);
					// Select has been low one half period: first edge now
					if (edge_ev) begin
						n.div_cnt = half_m1;
						n.sclk_lvl = !s.sclk_lvl;
						n.st = ST_RUN;
					end
				end
				ST_RUN: begin
					n.div_cnt = 11'(s.div_cnt - 11'h001);
					if (edge_ev) begin
						n.div_cnt = half_m1;
						n.sclk_lvl = !s.sclk_lvl;
						if (done) begin
							n.st = ST_TRAIL;
						end
					end
				end
				ST_TRAIL: begin
					n.div_cnt = 11'(s.div_cnt - 11'h001);
					if (s.div_cnt == 11'h000) begin
						n.div_cnt = 11'h000;
						n.st = ST_IDLE;
					end
				end
			endcase
		end else begin
			// Slave: load on selection and after each word while held low
			n.st = ST_IDLE;
			n.div_cnt = 11'h000;
			n.sclk_lvl = 1'b0;
			if ((n.sel && !s.sel) || done) begin
				n.edge_cnt = 6'h00;
				if (!s.tx_empty) begin
					n.sh = s.tx_buf;
					n.tx_empty = 1'b1;
				end
			end
			if (!n.sel) begin
				n.edge_cnt = 6'h00;
			end
		end

		// Word length flip as master drops everything back to reset status
		if (wlen_chg) begin
			n.st = ST_IDLE;
			n.sclk_lvl = 1'b0;
			n.edge_cnt = 6'h00;
			n.div_cnt = 11'h000;
			n.rx_full = 1'b0;
			n.fault = 1'b0;
			n.fault_armed = 1'b0;
			n.tx_empty = 1'b1;
			n.hi_pend = 1'b0;
			n.lo_pend = 1'b0;
		end

		// Another master pulled select low: step down and release pins
		if (mode_fault) begin
			n.master_sel = 1'b0;
			n.fault = 1'b1;
			n.st = ST_IDLE;
			n.sclk_lvl = 1'b0;
			n.edge_cnt = 6'h00;
			n.div_cnt = 11'h000;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= STATE_RST;
		end else begin
			s <= n;
		end
	end

	// Idle clock level follows polarity alone
	property p_idle_level;
		@(posedge clk) disable iff (!rstn)
		(s.st == ST_IDLE && s.master_sel) |-> (pin_out.sclk_o == s.clock_polarity);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");

	// Divider quiet unless a master transfer runs
	property p_div_quiet;
		@(posedge clk) disable iff (!rstn)
		(!s.master_sel || s.st == ST_IDLE) |-> (s.div_cnt == 11'h000);
	endproperty
	a_div_quiet: assert property (p_div_quiet) else $error("divider runs while idle");

	// Half period length in each run step follows the baud fields
	property p_half_period;
		@(posedge clk) disable iff (!rstn)
		(s.st == ST_RUN && s.div_cnt == 11'h000 && !mode_fault && !wlen_chg)
			|=> (s.div_cnt == half_m1);
	endproperty
	a_half_period: assert property (p_half_period) else $error("half period reload wrong");

	// Mode fault leaves a released, faulted slave
	property p_fault;
		@(posedge clk) disable iff (!rstn)
		mode_fault |=> (!s.master_sel && s.fault && s.st == ST_IDLE
			&& pin_out.sclk_oe_n && pin_out.mosi_oe_n && pin_out.miso_oe_n);
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not handled");

	// No fault can rise while select is our own output
	property p_no_fault_auto;
		@(posedge clk) disable iff (!rstn)
		(auto_ss && !s.fault) |=> !s.fault;
	endproperty
	a_no_fault_auto: assert property (p_no_fault_auto) else $error("fault with auto select");

	// Automatic select low throughout a transfer
	property p_auto_ss;
		@(posedge clk) disable iff (!rstn)
		(auto_ss && s.st != ST_IDLE) |-> (!pin_out.ss_n_o && !pin_out.ss_oe_n);
	endproperty
	a_auto_ss: assert property (p_auto_ss) else $error("select not low in transfer");

	// Unselected slave keeps its output floating and does not count edges
	property p_slave_hiz;
		@(posedge clk) disable iff (!rstn)
		(!s.master_sel && !s.sel) |-> (pin_out.miso_oe_n && s.edge_cnt == 6'h00);
	endproperty
	a_slave_hiz: assert property (p_slave_hiz) else $error("unselected slave active");

	// Word length flip returns to idle with reset status
	property p_wlen_abort;
		@(posedge clk) disable iff (!rstn)
		(wlen_chg && !mode_fault) |=> (s.st == ST_IDLE && !s.rx_full && !s.fault
			&& s.tx_empty);
	endproperty
	a_wlen_abort: assert property (p_wlen_abort) else $error("length change no abort");

	// Start: load, then select falls before the first clock edge
	sequence s_start;
		s.master_sel && s.st == ST_IDLE && !s.tx_empty && !mode_fault && !wlen_chg;
	endsequence
	sequence s_lead;
		s.st == ST_LEAD && pin_out.sclk_o == s.clock_polarity;
	endsequence
	property p_lead;
		@(posedge clk) disable iff (!rstn)
		s_start |=> s_lead;
	endproperty
	a_lead: assert property (p_lead) else $error("no lead half period");

	// Completion stores the word and raises rx full
	property p_rx_full;
		@(posedge clk) disable iff (!rstn)
		(done && !wlen_chg) |=> (s.rx_full && s.rx_data == $past(s.wlen ? fin
			: {8'h00, fin[7:0]}));
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("word not stored");

endmodule : scb_core

//--- tb/scb_core_tb.sv
// Self-checking bench of the serial core with an external slave model
`timescale 1ns/1ps
module scb_core_tb;
	import scb_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	scb_bus_req_t bus = '0;
	logic [7:0] rdata;
	scb_pin_in_t pin_in;
	scb_pin_out_t pin_out;
	logic m_sclk = 1'b0, m_mosi = 1'b0, m_ss_n = 1'b1, p_miso;
	logic p_clock_phase = 1'b0, p_lsb = 1'b0, p_w16 = 1'b0;
	logic [15:0] p_tx = '0, p_rx;
	logic [7:0] d = '0;
	logic ps = 1'b0, pss = 1'b1;
	int p_edges, n_mismatch = 0, checked = 0;
	int cnt = 0, nedge = 0, g_lead = 0, g_edge = 0, g_trail = 0;

	always #5 clk = ~clk;
	// Wire levels: the core wins wherever it drives, else the bench or the partner
	assign pin_in = '{sclk: pin_out.sclk_oe_n ? m_sclk : pin_out.sclk_o,
		mosi: pin_out.mosi_oe_n ? m_mosi : pin_out.mosi_o,
		miso: pin_out.miso_oe_n ? p_miso : pin_out.miso_o,
		ss_n: pin_out.ss_oe_n ? m_ss_n : pin_out.ss_n_o};
	scb_core scb_core_i (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.pin_in(pin_in), .pin_out(pin_out));
	scb_partner scb_partner_i (.sclk(pin_in.sclk), .ss_n(pin_in.ss_n), .mosi(pin_in.mosi),
		.miso(p_miso), .clock_phase(p_clock_phase), .lsb(p_lsb), .w16(p_w16), .tx_word(p_tx),
		.rx_word(p_rx), .n_edge(p_edges));

	// Cycle gaps from select fall to first edge, between edges, last edge to select rise;
	// sampled on the falling edge so that the core's outputs have settled
	always @(negedge clk) begin
		cnt++;
		if (pin_out.ss_n_o === 1'b0 && pin_out.sclk_o !== ps) begin
			if (nedge == 0) g_lead = cnt;
			else g_edge = cnt;
			nedge++;
			cnt = 0;
		end
		if (pin_out.ss_n_o !== pss) begin
			if (pss === 1'b0) g_trail = cnt;
			nedge = 0;
			cnt = 0;
		end
		ps = pin_out.sclk_o;
		pss = pin_out.ss_n_o;
	end

	task automatic check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk) bus <= '0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus <= '0;
		#1 d = rdata;
	endtask : rd
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// One master word against the slave model, timing judged from the half period
	task automatic xfer(input logic [7:0] c1, input logic [7:0] bd, input logic w,
		input logic [15:0] v);
		int h;
		int i;
		h = (int'(bd[6:4]) + 1) << bd[2:0];
		p_clock_phase = c1[C1_CLOCK_PHASE];
		p_lsb = c1[C1_LSB_FIRST_ENABLE];
		p_w16 = w;
		p_tx = ~v;
		wr(REG_CTRL2, {1'b0, w, 6'h10});
		wr(REG_BAUD, bd);
		wr(REG_CTRL1, c1);
		rd(REG_STATUS);
		check(d[ST_TXEMPTY] === 1'b1, "transmit buffer not empty");
		if (w) wr(REG_DATA_HI, v[15:8]);
		wr(REG_DATA_LO, v[7:0]);
		d = 8'h00;
		for (i = 0; i < 4000 && d[ST_RXFULL] !== 1'b1; i++) rd(REG_STATUS);
		for (i = 0; i < 100 && pin_out.ss_n_o !== 1'b1; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1 check(d[ST_RXFULL] === 1'b1, "no receive");
		check(p_edges == (w ? 32 : 16), "edge count");
		check(g_lead == h && g_edge == h && g_trail == h, "timing");
		check(pin_out.sclk_o === c1[C1_CLOCK_POLARITY], "idle clock level");
		check(pin_out.ss_oe_n === 1'b0 && pin_out.ss_n_o === 1'b1, "idle select");
		check((w ? p_rx : {8'h00, c1[0] ? p_rx[15:8] : p_rx[7:0]}) ===
			(w ? v : {8'h00, v[7:0]}), "partner received");
		if (w) begin
			rd(REG_DATA_HI);
			check(d === p_tx[15:8], "high byte");
		end
		rd(REG_DATA_LO);
		check(d === p_tx[7:0], "low byte");
	endtask : xfer

	// Length change during the lead half period of a word sends the sequencer home and clears status
	task automatic abort_on_length;
		wr(REG_CTRL2, 8'h00);
		wr(REG_CTRL1, 8'h12);
		repeat (2) @(posedge clk);
		#1 check(pin_out.ss_oe_n === 1'b1, "select driven without fault enable");
		wr(REG_CTRL2, 8'h10);
		wr(REG_BAUD, 8'h77);
		wr(REG_DATA_LO, 8'h55);
		repeat (8) @(posedge clk);
		#1 check(pin_out.ss_n_o === 1'b0, "word not started");
		wr(REG_CTRL2, 8'h50);
		repeat (3) @(posedge clk);
		#1 check(pin_out.ss_n_o === 1'b1 && pin_out.sclk_o === 1'b0, "no abort");
		rd(REG_STATUS);
		check(d === 8'h20, "status not cleared");
	endtask : abort_on_length

	// Another master pulls select low while select is a fault input
	task automatic mode_fault;
		wr(REG_CTRL2, 8'h10);
		wr(REG_CTRL1, 8'h10);
		m_ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check(pin_out.sclk_oe_n === 1'b1 && pin_out.mosi_oe_n === 1'b1 &&
			pin_out.miso_oe_n === 1'b1, "outputs kept");
		rd(REG_STATUS);
		check(d[ST_FAULT] === 1'b1, "fault flag");
		@(posedge clk) m_ss_n <= 1'b1;
		wr(REG_CTRL1, 8'h00);
		rd(REG_STATUS);
		check(d[ST_FAULT] === 1'b0, "fault kept");
	endtask : mode_fault

	// Bench acts as master, phase zero, slowly enough for synchronous sampling
	task automatic slave_word;
		int i;
		logic [7:0] got;
		logic [7:0] sent;
		sent = 8'h96;
		wr(REG_DATA_LO, 8'hC3);
		#1 check(pin_out.miso_oe_n === 1'b1, "unselected slave drives");
		@(posedge clk) m_ss_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1 check(pin_out.miso_oe_n === 1'b0 && pin_out.miso_o === 1'b1, "first bit");
		for (i = 7; i >= 0; i--) begin
			@(posedge clk) m_mosi <= sent[i];
			repeat (3) @(posedge clk);
			#1 got[i] = pin_out.miso_o;
			@(posedge clk) m_sclk <= 1'b1;
			repeat (3) @(posedge clk);
			m_sclk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		m_ss_n <= 1'b1;
		rd(REG_STATUS);
		check(d[ST_RXFULL] === 1'b1, "slave no receive");
		rd(REG_DATA_LO);
		check(d === sent, "slave received");
		check(got === 8'hC3, "slave sent");
	endtask : slave_word

	// Main sequence; the slave word uses the length the fault test wrote last
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(REG_STATUS);
		check(d === 8'h20, "status reset value");
		wr(REG_DATA_HI, 8'h5A);
		rd(REG_DATA_HI);
		check(d === 8'h00, "high byte in 8-bit mode");
		xfer(8'h12, 8'h00, 1'b0, 16'h00A5);
		xfer(8'h16, 8'h21, 1'b0, 16'h003C);
		xfer(8'h1A, 8'h70, 1'b0, 16'h0081);
		xfer(8'h1E, 8'h13, 1'b0, 16'h00E7);
		xfer(8'h13, 8'h01, 1'b0, 16'h0096);
		xfer(8'h16, 8'h00, 1'b1, 16'hC35A);
		abort_on_length();
		mode_fault();
		slave_word();
		tally_and_finish();
	end

	// Watchdog well beyond the longest expected run
	initial begin
		#300000;
		check(1'b0, "watchdog expired");
		tally_and_finish();
	end
endmodule : scb_core_tb

//--- tb/scb_partner.sv
// Behavioural external serial slave that answers the core in master mode
`timescale 1ns/1ps
module scb_partner (
	// Serial lines
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// Format and data
	input wire logic clock_phase,
	input wire logic lsb,
	input wire logic w16,
	input wire logic [15:0] tx_word,
	output logic [15:0] rx_word,
	output int n_edge
);
	logic [15:0] t;
	// Bit i of the outgoing word in wire order
	function automatic logic pick(input int i);
		return lsb ? t[i] : t[(w16 ? 15 : 7) - i];
	endfunction : pick
	initial begin
		miso = 1'b0;
		rx_word = '0;
		n_edge = 0;
	end
	// Select opens a word; phase zero puts its first bit out at once
	always @(negedge ss_n) begin
		n_edge = 0;
		t = tx_word;
		rx_word = '0;
		if (!clock_phase) miso = pick(0);
	end
	// Released line shows the inverse, so a stale level never passes as data
	always @(posedge ss_n) miso = ~miso;
	// Edges alternate between sampling and presenting; the count closes the word
	always @(sclk) begin
		if (!ss_n) begin
			n_edge++;
			if (n_edge[0] != clock_phase) begin
				rx_word = lsb ? {mosi, rx_word[15:1]} : {rx_word[14:0], mosi};
			end else if (n_edge < (w16 ? 32 : 16)) begin
				miso = pick(n_edge / 2);
			end
		end
	end
endmodule : scb_partner
